// >>> bench/iag_mem_model.sv
// memory side model: register load returns and quads for the align fifo
`timescale 1ns/10ps
module iag_mem_model
(
  input wire logic clk, // core clock
  input wire logic [1:0] mem_req, // address valid
  input wire logic [1:0][31:0] mem_addr, // address
  input wire logic [1:0] mem_fifo, // align path
  input wire logic [1:0] arm, // answer register loads
  input wire logic [31:0] lat, // answer delay in cycles
  output logic [1:0] ld_ret_valid, // load return
  output logic [1:0][31:0] ld_ret_data, // load data
  output logic fifo_data_valid, // quad valid
  output logic [127:0] fifo_data // quad
);
  initial
  begin
    ld_ret_valid = 2'h0;
    ld_ret_data = '1;
    fifo_data_valid = 1'b0;
    fifo_data = '1;
  end
  // busy while answering, so one request at a time per unit
  task automatic serve(int u);
    logic [127:0] q;
    logic [31:0] d;
    @(posedge clk);
    q = {mem_addr[u], 32'h1, 32'h2, 32'h3};
    d = mem_addr[u] ^ 32'h5a5a_0000;
    if (mem_req[u] && mem_fifo[u])
    begin
      repeat (lat) @(posedge clk);
      #1 fifo_data_valid = 1'b1;
      fifo_data = q;
      @(posedge clk);
      #1 fifo_data = ~q;
      @(posedge clk);
      #1 fifo_data_valid = 1'b0;
      // released lines show the inverse of the last quad
      fifo_data = q;
    end
    else if (mem_req[u] && arm[u])
    begin
      repeat (lat) @(posedge clk);
      #1 ld_ret_valid[u] = 1'b1;
      ld_ret_data[u] = d;
      @(posedge clk);
      #1 ld_ret_valid[u] = 1'b0;
      ld_ret_data[u] = ~d;
    end
  endtask : serve
  initial
    forever serve(0);
  initial
    forever serve(1);
endmodule : iag_mem_model

// >>> bench/iag_monitor.sv
// concurrent checks on the integer address generator ports
`timescale 1ns/10ps
module iag_monitor
(
  input wire logic clk, // core clock
  input wire logic rst, // async reset
  input wire iag_pkg::iag_instr_type [1:0] instr, // instructions
  input wire logic [1:0] instr_valid, // offered
  input wire logic [1:0] instr_ready, // taken
  input wire logic [1:0] mem_req, // address out
  input wire logic [1:0][31:0] mem_addr, // address
  input wire iag_pkg::iag_size_type [1:0] mem_size, // size
  input wire logic [1:0] mem_fifo, // fifo path
  input wire logic [1:0] misalign, // forced down
  input wire logic fifo_data_valid, // quad in
  input wire logic align_valid // quad out
);
  import iag_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire tk = instr_valid[0] && instr_ready[0];
  wire ad = tk && instr[0].op[3];
  wire im = ad && instr[0].op == IAG_OP_ADDR_IMM && !instr[0].use_fifo;
  wire qm = instr[0].imm[1:0] != 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  a_req_follows: assert property (ad |=> mem_req[0])
    else $error("no address after address op");
  a_alu_quiet: assert property (tk && !instr[0].op[3] |=> !mem_req[0])
    else $error("alu op issued an address");
  a_imm_value: assert property (im && instr[0].size == IAG_SIZE_SINGLE
    |=> mem_addr[0] == $past(instr[0].imm))
    else $error("immediate address wrong");
  a_size_follows: assert property (ad && !instr[0].use_fifo
    |=> mem_size[0] == $past(instr[0].size))
    else $error("access size wrong");
  a_fifo_quad: assert property (ad && instr[0].use_fifo
    |=> mem_fifo[0] && mem_size[0] == IAG_SIZE_QUAD && mem_addr[0][1:0] == 2'h0)
    else $error("fifo load not a quad");
  a_own_align: assert property (mem_req[0] && mem_size[0] == IAG_SIZE_QUAD
    |-> mem_addr[0][1:0] == 2'h0)
    else $error("quad address unaligned");
  a_misalign_flag: assert property (im && instr[0].size == IAG_SIZE_QUAD
    |=> misalign[0] == $past(qm))
    else $error("misalign flag wrong");
  a_align_cause: assert property (align_valid |-> $past(fifo_data_valid))
    else $error("quad out without quad in");
  a_load_stall: assert property (tk && instr[0].load_reg ##1 instr_valid[0]
    && instr[0].op[3] && instr[0].srca == $past(instr[0].dst) |-> !instr_ready[0])
    else $error("no stall on pending load");
  a_unit1_req: assert property (instr_valid[1] && instr_ready[1]
    && instr[1].op[3] |=> mem_req[1])
    else $error("unit 1 gave no address");
endmodule : iag_monitor
bind iag_integer_address_generator iag_monitor i_mon
(
  .clk, .rst, .instr, .instr_valid, .instr_ready, .mem_req, .mem_addr,
  .mem_size, .mem_fifo, .misalign, .fifo_data_valid, .align_valid
);

// >>> bench/tb_integer_address_generator.sv
// self-checking bench of the integer address generator
`timescale 1ns/10ps
module tb_integer_address_generator;
  import iag_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  iag_instr_type [1:0] instr = '0;
  logic [1:0] instr_valid = 2'h0, arm = 2'h0, instr_ready, mem_req, mem_fifo, misalign;
  logic [1:0] ld_ret_valid;
  logic [1:0][31:0] mem_addr, ld_ret_data;
  iag_size_type [1:0] mem_size;
  logic fifo_flush = 1'b0;
  logic fifo_data_valid, align_valid;
  logic [127:0] fifo_data, align_data;
  int lat = 1;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  iag_integer_address_generator i_dut
  (
    .clk, .rst, .instr, .instr_valid, .instr_ready, .mem_req, .mem_addr, .mem_size,
    .mem_fifo, .misalign, .ld_ret_valid, .ld_ret_data, .fifo_data_valid, .fifo_data,
    .fifo_flush, .align_valid, .align_data
  );
  iag_mem_model i_mem
  (
    .clk, .mem_req, .mem_addr, .mem_fifo, .arm, .lat, .ld_ret_valid, .ld_ret_data,
    .fifo_data_valid, .fifo_data
  );
  initial
    forever #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(logic [127:0] seen, logic [127:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  function automatic iag_instr_type mk(iag_op_type o, logic [4:0] d, a, logic [31:0] im);
    iag_instr_type i;
    i = '0;
    i.op = o;
    i.dst = d;
    i.srca = a;
    i.srcb = IAG_NO_REG;
    i.use_imm = 1'b1;
    i.imm = im;
    return i;
  endfunction : mk
  // offer and hold until ready is seen at an edge; valid stays up for back to back
  task automatic issue(int u, iag_instr_type i, output int w);
    logic r;
    instr[u] = i;
    instr_valid[u] = 1'b1;
    w = 0;
    do
    begin
      #1 r = instr_ready[u];
      @(posedge clk);
      #1 w++;
    end
    while (!r && w < 40);
  endtask : issue
  task automatic ex(int u, iag_instr_type i, logic [31:0] a);
    int w;
    issue(u, i, w);
    chk(mem_req[u], 1'b1);
    chk(mem_addr[u], a);
  endtask : ex
  //////////////////////////////////////////////////////////////////////////////
  task automatic s_alu();
    iag_op_type ops [5] = '{IAG_OP_ADD, IAG_OP_SUB, IAG_OP_AND, IAG_OP_OR, IAG_OP_XOR};
    logic [31:0] e [5] = '{32'h1ef, 32'hffff_fff1, 32'hf0, 32'hff, 32'h0f};
    int w;
    for (int k = 0; k < 5; k++)
    begin
      issue(0, mk(IAG_OP_PASS, 5'h10, 5'h1f, 32'hf0), w);
      issue(0, mk(ops[k], 5'h11, 5'h10, 32'hff), w);
      chk(w, 1);
      ex(0, mk(IAG_OP_ADDR_POST, 5'h1f, 5'h11, 32'h0), e[k]);
    end
    issue(0, mk(IAG_OP_PASS, 5'h12, 5'h1f, 32'h28), w);
    ex(0, mk(IAG_OP_ADDR_PRE, 5'h1f, 5'h12, 32'h4), 32'h2c);
    ex(0, mk(IAG_OP_ADDR_POST, 5'h1f, 5'h12, 32'h4), 32'h2c);
    ex(0, mk(IAG_OP_ADDR_POST, 5'h1f, 5'h12, 32'h0), 32'h30);
    ex(0, mk(IAG_OP_ADDR_IMM, 5'h1f, 5'h1f, 32'h123), 32'h123);
    instr_valid[0] = 1'b0;
  endtask : s_alu
  task automatic s_size();
    iag_instr_type i;
    for (int k = 0; k < 3; k++)
    begin
      i = mk(IAG_OP_ADDR_IMM, 5'h1f, 5'h1f, 32'h13);
      i.size = iag_size_type'(k);
      ex(0, i, 32'h13 & ~((32'h1 << k) - 32'h1));
      chk(mem_size[0], i.size);
      chk(misalign[0], k != 0);
    end
    instr_valid[0] = 1'b0;
  endtask : s_size
  // unit 1 buffer 1 with an odd length; unit 0 buffer 2 in bit-reverse
  task automatic s_circ();
    iag_instr_type i;
    int w;
    issue(1, mk(IAG_OP_PASS, 5'h09, 5'h1f, 32'ha), w);
    issue(1, mk(IAG_OP_PASS, 5'h0d, 5'h1f, 32'h5), w);
    issue(1, mk(IAG_OP_PASS, 5'h01, 5'h1f, 32'hd), w);
    i = mk(IAG_OP_ADDR_POST, 5'h1f, 5'h01, 32'h3);
    i.mode = IAG_MODE_CIRC;
    ex(1, i, 32'hd);
    i.imm = 32'hffff_fffc;
    ex(1, i, 32'hb);
    ex(1, mk(IAG_OP_ADDR_POST, 5'h1f, 5'h01, 32'h0), 32'hc);
    instr_valid[1] = 1'b0;
    issue(0, mk(IAG_OP_PASS, 5'h0a, 5'h1f, 32'h64), w);
    issue(0, mk(IAG_OP_PASS, 5'h02, 5'h1f, 32'h64), w);
    i = mk(IAG_OP_ADDR_POST, 5'h1f, 5'h02, 32'h4);
    i.mode = IAG_MODE_BITREV;
    ex(0, i, 32'h64);
    ex(0, i, 32'h68);
    ex(0, mk(IAG_OP_ADDR_POST, 5'h1f, 5'h02, 32'h0), 32'h66);
    instr_valid[0] = 1'b0;
  endtask : s_circ
  task automatic s_stall();
    iag_instr_type i;
    int w;
    for (int k = 0; k < 2; k++)
    begin
      // idle cycle so the model never answers the previous address as a load
      @(posedge clk) #1;
      arm[0] = 1'b1;
      lat = 4 * k;
      i = mk(IAG_OP_ADDR_IMM, 5'h14, 5'h1f, 32'h40 + 32'(16 * k));
      i.load_reg = 1'b1;
      ex(0, i, 32'h40 + 32'(16 * k));
      issue(0, mk(IAG_OP_ADDR_POST, 5'h1f, 5'h14, 32'h0), w);
      arm[0] = 1'b0;
      instr_valid[0] = 1'b0;
      chk(w > lat + 1, 1'b1);
      chk(mem_addr[0], 32'h5a5a_0040 + 32'(16 * k));
    end
  endtask : s_stall
  task automatic s_fifo();
    iag_instr_type i;
    logic [127:0] q;
    logic [255:0] t;
    q = {32'h0, 32'h1, 32'h2, 32'h3};
    t = {~q, q} >> 80;
    lat = 2;
    i = mk(IAG_OP_ADDR_IMM, 5'h1f, 5'h1f, 32'h2);
    i.use_fifo = 1'b1;
    i.half = 1'b1;
    ex(0, i, 32'h0);
    chk(mem_size[0], IAG_SIZE_QUAD);
    instr_valid[0] = 1'b0;
    for (int n = 0; n < 20 && align_valid !== 1'b1; n++)
      @(posedge clk) #1;
    chk(align_valid, 1'b1);
    chk(align_data, t[127:0]);
    // after a flush the next quad only refills, so a stale held quad never emits
    fifo_flush = 1'b1;
    @(posedge clk) #1 fifo_flush = 1'b0;
    t = {~q, q} >> 32;
    i.imm = 32'h1;
    i.half = 1'b0;
    ex(0, i, 32'h0);
    instr_valid[0] = 1'b0;
    for (int n = 0; n < 20 && align_valid !== 1'b1; n++)
      @(posedge clk) #1;
    chk(align_valid, 1'b1);
    chk(align_data, t[127:0]);
  endtask : s_fifo
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    s_alu();
    s_size();
    s_circ();
    s_stall();
    s_fifo();
    test_done();
  end
endmodule : tb_integer_address_generator

// >>> logic/iag_integer_address_generator.sv
// two integer address units with dependency check and load alignment fifo
// Overview of operation
// [RULE_01] two integer units, each with its own 31-word register file
// [RULE_02] addresses by immediate, pre-modify or post-modify indirect addressing
// [RULE_03] each unit drives a memory address and writes back the pointer
// [RULE_04] each address carries a single, dual or quad word size
// [RULE_05] four circular buffers per unit, eight in total
// [RULE_06] circular pointers wrap automatically past either buffer end
// [RULE_07] modulus and bit-reverse work for any base and length
// [RULE_08] one-stage pipeline, results usable in the next cycle
// [RULE_09] issue stalls while a needed register result is not yet available; base and length reads of circular and bit-reverse updates are not checked
// [RULE_10] units also perform general integer arithmetic and logic
// [RULE_11] one quad-deep alignment fifo builds quads from nonaligned loads
// [RULE_12] loads outside the fifo must be aligned to their own size
// [RULE_13] memory reached as 32/64/128-bit words, 16-bit through the fifo
// [RULE_14] bit-reverse adds with carry running from msb toward lsb
// [RULE_15] circular update subtracts length at end, adds length below base
`timescale 1ns/10ps
module iag_integer_address_generator
(
  input wire logic clk, // core clock, 125 MHz
  input wire logic rst, // async reset, high
  input wire iag_pkg::iag_instr_type [1:0] instr, // instruction per unit
  input wire logic [1:0] instr_valid, // instruction present per unit
  output logic [1:0] instr_ready, // instruction can be taken this cycle
  output logic [1:0] mem_req, // address valid per unit
  output logic [1:0][31:0] mem_addr, // word address per unit
  output iag_pkg::iag_size_type [1:0] mem_size, // access size per unit
  output logic [1:0] mem_fifo, // access goes through the align fifo
  output logic [1:0] misalign, // address outside the fifo was forced down to its size
  input wire logic [1:0] ld_ret_valid, // load data for a unit register
  input wire logic [1:0][31:0] ld_ret_data, // that load data
  input wire logic fifo_data_valid, // aligned quad arrives for the fifo
  input wire logic [127:0] fifo_data, // that quad
  input wire logic fifo_flush, // drop the held quad
  output logic align_valid, // assembled quad ready, one cycle
  output logic [127:0] align_data // assembled quad
);
  import iag_pkg::*;

  // true when instruction touches register idx through srca, srcb or dst
  function automatic logic dep_hit(input iag_instr_type ins, input logic [4:0] idx);
    logic is_alu;
    logic upd;
    is_alu = (ins.op >= IAG_OP_ADD) && (ins.op <= IAG_OP_PASS);
    upd = (ins.op == IAG_OP_ADDR_PRE) || (ins.op == IAG_OP_ADDR_POST);
    dep_hit = ((is_alu || upd) && ins.srca == idx) ||
              (is_alu && ins.dst == idx) ||
              ((is_alu || upd) && !ins.use_imm && ins.srcb == idx) ||
              (ins.load_reg && ins.dst == idx);
  endfunction : dep_hit

  function automatic logic is_misaligned(input logic [31:0] a, input iag_size_type s);
    is_misaligned = (s == IAG_SIZE_DUAL && a[0]) || (s == IAG_SIZE_QUAD && a[1:0] != 2'h0);
  endfunction : is_misaligned

  function automatic logic [31:0] align_down(input logic [31:0] a, input iag_size_type s);
    align_down = (s == IAG_SIZE_QUAD) ? {a[31:2], 2'h0} :
                 (s == IAG_SIZE_DUAL) ? {a[31:1], 1'b0} : a;
  endfunction : align_down

  ////////////////////////////////////////////////////////////////////////////
  iag_unit_if ubus [IAG_UNITS] ();

  logic [1:0] fifo_load;
  logic [1:0][2:0] fifo_off;

  genvar gu;
  generate
    // [RULE_05] four buffers in each of two units
    for (gu = 0; gu < IAG_UNITS; gu++)
    begin : g_unit
      logic pend;
      logic [4:0] pend_idx;
      logic req;
      logic [31:0] addr;
      iag_size_type size;
      logic via_fifo;
      logic bad;

      iag_integer_address_unit u_unit
      (
        .clk(clk),
        .rst(rst),
        .bus(ubus[gu])
      );

      // [RULE_09] stall on a srca, srcb or dst register still waiting for load data
      // a return in the stall cycle frees issue one cycle later, keeping ready short
      wire stall = pend && (dep_hit(instr[gu], pend_idx) || instr[gu].load_reg);
      wire take = instr_valid[gu] && !stall;
      assign instr_ready[gu] = !stall;
      assign ubus[gu].go = take;
      assign ubus[gu].instr = instr[gu];
      assign ubus[gu].wb_en = pend && ld_ret_valid[gu];
      assign ubus[gu].wb_idx = pend_idx;
      assign ubus[gu].wb_data = ld_ret_data[gu];

      wire iag_instr_type ins = instr[gu];
      // [RULE_13] 16-bit grain only through the fifo, which reads quads
      wire uses_fifo = ins.use_fifo;
      // [RULE_04] size chosen by the instruction
      wire iag_size_type eff_size = uses_fifo ? IAG_SIZE_QUAD : ins.size;
      // [RULE_12] size alignment outside the fifo
      wire mis = !uses_fifo && is_misaligned(ubus[gu].addr, eff_size);
      wire [31:0] out_addr = uses_fifo ? align_down(ubus[gu].addr, IAG_SIZE_QUAD) :
                                         align_down(ubus[gu].addr, eff_size);
      wire start_load = take && ubus[gu].addr_en && ins.load_reg;

      assign fifo_load[gu] = ubus[gu].addr_en && uses_fifo;
      assign fifo_off[gu] = {ubus[gu].addr[1:0], ins.half};

      // one load in flight per unit; a second load waits for the return
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          pend <= 1'b0;
        else if (start_load)
          pend <= 1'b1;
        else if (ld_ret_valid[gu])
          pend <= 1'b0;
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          pend_idx <= IAG_NO_REG;
        else if (start_load)
          pend_idx <= ins.dst;
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          req <= 1'b0;
          addr <= IAG_RST_WORD;
          size <= IAG_SIZE_SINGLE;
          via_fifo <= 1'b0;
          bad <= 1'b0;
        end
        else
        begin
          req <= ubus[gu].addr_en;
          addr <= out_addr;
          size <= eff_size;
          via_fifo <= fifo_load[gu];
          bad <= ubus[gu].addr_en && mis;
        end
      end

      assign mem_req[gu] = req;
      assign mem_addr[gu] = addr;
      assign mem_size[gu] = size;
      assign mem_fifo[gu] = via_fifo;
      assign misalign[gu] = bad;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // [RULE_11] one quad deep alignment fifo
  iag_fifo_state_type fifo_state;
  iag_fifo_state_type next_fifo_state;
  logic [127:0] held_quad;
  logic [2:0] offset;

  // unit 0 wins when both units start a fifo load together
  wire [2:0] next_offset = fifo_load[0] ? fifo_off[0] : fifo_off[1];
  wire [255:0] pair = {fifo_data, held_quad};
  wire [6:0] shift = {offset, 4'h0};
  wire [127:0] assembled = pair[shift +: IAG_QW];
  wire emit = (fifo_state == IAG_FIFO_PRIMED) && fifo_data_valid && !fifo_flush;

  // flush wins over an arriving quad, so a stale held quad never emits
  always_comb
  begin
    next_fifo_state = fifo_state;
    case (fifo_state)
      IAG_FIFO_EMPTY:
        if (fifo_data_valid && !fifo_flush)
          next_fifo_state = IAG_FIFO_PRIMED;
      IAG_FIFO_PRIMED:
        if (fifo_flush)
          next_fifo_state = IAG_FIFO_EMPTY;
      default:
        next_fifo_state = IAG_FIFO_EMPTY;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_state <= IAG_FIFO_EMPTY;
      held_quad <= IAG_RST_QUAD;
      offset <= IAG_RST_OFFSET;
    end
    else
    begin
      fifo_state <= next_fifo_state;
      if (fifo_data_valid)
        held_quad <= fifo_data;
      if (|fifo_load)
        offset <= next_offset;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      align_valid <= 1'b0;
      align_data <= IAG_RST_QUAD;
    end
    else
    begin
      align_valid <= emit;
      if (emit)
        align_data <= assembled;
    end
  end

endmodule : iag_integer_address_generator

// >>> logic/iag_integer_address_unit.sv
// one integer address unit: register file, address generator and integer alu
`timescale 1ns/10ps
module iag_integer_address_unit
(
  input wire logic clk, // core clock
  input wire logic rst, // async reset, high
  iag_unit_if.unit bus // instruction in, address out
);
  import iag_pkg::*;

  logic [31:0] rf [IAG_RF_WORDS];

  // index 31 is not a register and reads as zero
  function automatic logic [31:0] rf_rd(input logic [4:0] idx);
    rf_rd = (idx == IAG_NO_REG) ? IAG_RST_WORD : rf[idx];
  endfunction : rf_rd

  function automatic logic [31:0] bit_rev(input logic [31:0] v);
    for (int i = 0; i < IAG_DW; i++)
    begin
      bit_rev[i] = v[IAG_DW - 1 - i];
    end
  endfunction : bit_rev

  ////////////////////////////////////////////////////////////////////////////
  wire iag_instr_type ins = bus.instr;
  wire [31:0] opa = rf_rd(ins.srca);
  wire [31:0] opb = ins.use_imm ? ins.imm : rf_rd(ins.srcb);
  wire [4:0] cb_sel = {3'h0, ins.srca[1:0]};
  wire [31:0] cb_base = rf_rd(IAG_CB_BASE_IDX + cb_sel);
  wire [31:0] cb_len = rf_rd(IAG_CB_LEN_IDX + cb_sel);
  wire own_cbuf = (ins.srca < 5'(IAG_CBUFS));
  wire [31:0] lin_sum = opa + opb;
  wire [32:0] cb_end = {1'b0, cb_base} + {1'b0, cb_len};
  // [RULE_15] subtract or add length
  wire [31:0] circ_sum = ({1'b0, lin_sum} >= cb_end) ? lin_sum - cb_len :
                         (lin_sum < cb_base) ? lin_sum + cb_len : lin_sum;
  // [RULE_14] reverse carry add
  wire [31:0] rev_sum = cb_base + bit_rev(bit_rev(opa - cb_base) + bit_rev(opb));
  // [RULE_06] wrap in hardware
  // [RULE_07] any base and length
  wire [31:0] upd = (ins.mode == IAG_MODE_CIRC && own_cbuf) ? circ_sum :
                    (ins.mode == IAG_MODE_BITREV && own_cbuf) ? rev_sum : lin_sum;

  // [RULE_10] integer alu operations
  wire [31:0] alu_res = (ins.op == IAG_OP_ADD) ? lin_sum :
                        (ins.op == IAG_OP_SUB) ? opa - opb :
                        (ins.op == IAG_OP_AND) ? (opa & opb) :
                        (ins.op == IAG_OP_OR) ? (opa | opb) :
                        (ins.op == IAG_OP_XOR) ? (opa ^ opb) : opb;
  wire is_alu = (ins.op >= IAG_OP_ADD) && (ins.op <= IAG_OP_PASS);
  wire is_upd = (ins.op == IAG_OP_ADDR_PRE) || (ins.op == IAG_OP_ADDR_POST);
  wire is_addr = is_upd || (ins.op == IAG_OP_ADDR_IMM);

  // [RULE_02] immediate, pre- or post-modify
  assign bus.addr = (ins.op == IAG_OP_ADDR_IMM) ? ins.imm :
                    (ins.op == IAG_OP_ADDR_PRE) ? upd : opa;
  // [RULE_03] address out
  assign bus.addr_en = bus.go && is_addr;

  // [RULE_03] pointer write back
  wire wa_en = bus.go && (is_alu || is_upd);
  wire [4:0] wa_idx = is_alu ? ins.dst : ins.srca;
  wire [31:0] wa_data = is_alu ? alu_res : upd;

  ////////////////////////////////////////////////////////////////////////////
  // [RULE_01] 31 word register file
  genvar gi;
  generate
    for (gi = 0; gi < IAG_RF_WORDS; gi++)
    begin : g_rf
      // [RULE_08] result usable next cycle
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          rf[gi] <= IAG_RST_WORD;
        else if (wa_en && wa_idx == 5'(gi))
          rf[gi] <= wa_data;
        else if (bus.wb_en && bus.wb_idx == 5'(gi))
          rf[gi] <= bus.wb_data;
      end
    end
  endgenerate

endmodule : iag_integer_address_unit

// >>> logic/iag_pkg.sv
// shared constants and types of the integer address generator
package iag_pkg;

  localparam int IAG_UNITS = 2;
  localparam int IAG_RF_WORDS = 31;
  localparam int IAG_CBUFS = 4;
  localparam int IAG_DW = 32;
  localparam int IAG_QW = 128;
  localparam int IAG_HALF_W = 16;
  localparam int IAG_IDX_W = 5;
  localparam logic [4:0] IAG_CB_BASE_IDX = 5'h08;
  localparam logic [4:0] IAG_CB_LEN_IDX = 5'h0c;
  localparam logic [4:0] IAG_NO_REG = 5'h1f;
  localparam logic [31:0] IAG_RST_WORD = 32'h0000_0000;
  localparam logic [127:0] IAG_RST_QUAD = 128'h0;
  localparam logic [2:0] IAG_RST_OFFSET = 3'h0;

  typedef enum logic [3:0]
  {
    IAG_OP_NOP = 4'h0,
    IAG_OP_ADD = 4'h1,
    IAG_OP_SUB = 4'h2,
    IAG_OP_AND = 4'h3,
    IAG_OP_OR = 4'h4,
    IAG_OP_XOR = 4'h5,
    IAG_OP_PASS = 4'h6,
    IAG_OP_ADDR_IMM = 4'h8,
    IAG_OP_ADDR_PRE = 4'h9,
    IAG_OP_ADDR_POST = 4'ha
  } iag_op_type;

  typedef enum logic [1:0]
  {
    IAG_MODE_LINEAR = 2'h0,
    IAG_MODE_CIRC = 2'h1,
    IAG_MODE_BITREV = 2'h2
  } iag_mode_type;

  typedef enum logic [1:0]
  {
    IAG_SIZE_SINGLE = 2'h0,
    IAG_SIZE_DUAL = 2'h1,
    IAG_SIZE_QUAD = 2'h2
  } iag_size_type;

  typedef enum logic
  {
    IAG_FIFO_EMPTY = 1'b0,
    IAG_FIFO_PRIMED = 1'b1
  } iag_fifo_state_type;

  typedef struct packed
  {
    iag_op_type op;
    iag_mode_type mode;
    iag_size_type size;
    logic use_fifo;
    logic half;
    logic load_reg;
    logic use_imm;
    logic [4:0] dst;
    logic [4:0] srca;
    logic [4:0] srcb;
    logic [31:0] imm;
  } iag_instr_type;

endpackage : iag_pkg

// >>> logic/iag_unit_if.sv
// carrier between the controller and one integer address unit
`timescale 1ns/10ps
interface iag_unit_if;
  import iag_pkg::*;
  logic go;
  iag_instr_type instr;
  logic wb_en;
  logic [4:0] wb_idx;
  logic [31:0] wb_data;
  logic [31:0] addr;
  logic addr_en;

  modport ctl
  (
    output go, instr, wb_en, wb_idx, wb_data,
    input addr, addr_en
  );

  modport unit
  (
    input go, instr, wb_en, wb_idx, wb_data,
    output addr, addr_en
  );
endinterface : iag_unit_if
